// file: hdl/csr_port_consts.svh
// constants for the csr port: widths, response codes, register map
`ifndef CSR_PORT_CONSTS_SVH
`define CSR_PORT_CONSTS_SVH
`define CSR_ADDR_W    4
`define CSR_DATA_W    32
`define CSR_STRB_W    4
`define CSR_PROT_W    3
`define CSR_RESP_W    2
`define RESP_OKAY     2'h0
`define RESP_EXOKAY   2'h1
`define RESP_SLVERR   2'h2
`define RESP_DECERR   2'h3
`define CSR_NUM_REGS  4
`define CSR_REG_RESET 32'h00000000
`define CSR_STATUS_WORD 2'h3
`define CSR_BYTE_W    8
`endif

// file: hdl/csr_port_pkg.sv
// types shared by both ends of the csr port
`default_nettype none
`include "csr_port_consts.svh"
package csr_port_pkg;
	typedef logic [`CSR_ADDR_W-1:0] csr_addr_t;
	typedef logic [`CSR_DATA_W-1:0] csr_data_t;
	typedef logic [`CSR_RESP_W-1:0] csr_resp_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_BUSY = 2'h1,
		ST_RESP = 2'h2
	} chan_state_t;
endpackage
`default_nettype wire

// file: hdl/csr_port_if.sv
// interface joining master and slave of the csr port
`timescale 1ns/1ps
`default_nettype none
`include "csr_port_consts.svh"
interface csr_port_if (
	input wire logic clk,
	input wire logic reset_n
);
	logic [`CSR_ADDR_W-1:0] awaddr;
	logic [`CSR_PROT_W-1:0] awprot;
	logic                   awvalid;
	logic                   awready;
	logic [`CSR_DATA_W-1:0] wdata;
	logic [`CSR_STRB_W-1:0] wstrb;
	logic                   wvalid;
	logic                   wready;
	logic [`CSR_RESP_W-1:0] bresp;
	logic                   bvalid;
	logic                   bready;
	logic [`CSR_ADDR_W-1:0] araddr;
	logic [`CSR_PROT_W-1:0] arprot;
	logic                   arvalid;
	logic                   arready;
	logic [`CSR_DATA_W-1:0] rdata;
	logic [`CSR_RESP_W-1:0] rresp;
	logic                   rvalid;
	logic                   rready;
	modport slave (
		input  clk, reset_n, awaddr, awprot, awvalid, wdata, wstrb, wvalid, bready,
		input  araddr, arprot, arvalid, rready,
		output awready, wready, bresp, bvalid, arready, rdata, rresp, rvalid
	);
	modport master (
		input  clk, reset_n, awready, wready, bresp, bvalid, arready, rdata, rresp, rvalid,
		output awaddr, awprot, awvalid, wdata, wstrb, wvalid, bready,
		output araddr, arprot, arvalid, rready
	);
endinterface
`default_nettype wire

// file: hdl/csr_slave.sv
// slave end of the csr port: four word registers behind the write and read channels
`timescale 1ns/1ps
`default_nettype none
`include "csr_port_consts.svh"
// Operation
// - reset idles machines, restores control registers
// - master holds write address until awready
// - write protection bits are ignored
// - master holds awvalid until awready edge
// - write address captured only on handshake
// - data written on w handshake, address present
// - master holds write data until wready
// - strobe bit n qualifies byte n
// - write response uses the four codes; this slave only ever sends OKAY
// - bvalid after write, held until bready
// - master takes response when bready high
// - master holds read address until arready
// - read protection bits are ignored
// - master holds arvalid until arready edge
// - read address captured only on handshake
// - rvalid with steady data until rready
// - read response uses the four codes; this slave only ever sends OKAY
module csr_slave
	import csr_port_pkg::*;
(
	csr_port_if.slave                 bus,
	output logic [`CSR_DATA_W-1:0]    ctrl_word [`CSR_NUM_REGS],
	input  wire logic [`CSR_DATA_W-1:0] status_word
);
	chan_state_t            wr_state;
	chan_state_t            rd_state;
	csr_addr_t              wr_addr;
	logic                   addr_held;
	logic                   data_held;
	csr_data_t              wdata_hold;
	logic [`CSR_STRB_W-1:0] wstrb_hold;
	logic                   aw_fire;
	logic                   w_fire;
	logic                   ar_fire;
	logic                   b_fire;
	logic                   r_fire;
	logic                   do_write;
	csr_addr_t              eff_addr;
	csr_data_t              eff_data;
	logic [`CSR_STRB_W-1:0] eff_strb;
	csr_data_t              read_value;

	// word index inside the 16-byte window; the low two bits are not used
	function automatic logic [1:0] word_index(input csr_addr_t a);
		return a[3:2];
	endfunction

	// lanes whose strobe bit is low keep their old byte
	function automatic csr_data_t lane_merge(
		input csr_data_t              old_word,
		input csr_data_t              new_word,
		input logic [`CSR_STRB_W-1:0] strb
	);
		csr_data_t merged;
		merged = old_word;
		for (int b = 0; b < `CSR_STRB_W; b++) begin
			if (strb[b]) begin
				merged[`CSR_BYTE_W*b +: `CSR_BYTE_W] = new_word[`CSR_BYTE_W*b +: `CSR_BYTE_W];
			end
		end
		return merged;
	endfunction

	// both prot buses are deliberately left unread
	assign bus.awready = (wr_state == ST_IDLE) && !addr_held;
	assign bus.wready  = (wr_state == ST_IDLE) && !data_held;
	assign bus.arready = (rd_state == ST_IDLE);
	assign aw_fire     = bus.awvalid && bus.awready;
	assign w_fire      = bus.wvalid && bus.wready;
	assign ar_fire     = bus.arvalid && bus.arready;
	assign b_fire      = bus.bvalid && bus.bready;
	assign r_fire      = bus.rvalid && bus.rready;
	assign eff_addr    = addr_held ? wr_addr : bus.awaddr;
	assign eff_data    = data_held ? wdata_hold : bus.wdata;
	assign eff_strb    = data_held ? wstrb_hold : bus.wstrb;
	// write once both address and data are in, whichever came first
	assign do_write    = (wr_state == ST_IDLE) && (aw_fire || addr_held) && (w_fire || data_held);
	// word 3 shows live status, so a write there is stored but never read back
	assign read_value  = (word_index(bus.araddr) == `CSR_STATUS_WORD) ? status_word
		: ctrl_word[word_index(bus.araddr)];

	// held flags clear when the write fires, which also covers address and data in one cycle
	always_ff @(posedge bus.clk or negedge bus.reset_n) begin
		if (!bus.reset_n) begin
			addr_held <= 1'b0;
		end else if (do_write) begin
			addr_held <= 1'b0;
		end else if (aw_fire) begin
			addr_held <= 1'b1;
		end
	end

	always_ff @(posedge bus.clk or negedge bus.reset_n) begin
		if (!bus.reset_n) begin
			wr_addr <= '0;
		end else if (aw_fire) begin
			wr_addr <= bus.awaddr;
		end
	end

	always_ff @(posedge bus.clk or negedge bus.reset_n) begin
		if (!bus.reset_n) begin
			data_held <= 1'b0;
		end else if (do_write) begin
			data_held <= 1'b0;
		end else if (w_fire) begin
			data_held <= 1'b1;
		end
	end

	// data and strobes kept for a write whose address comes later
	always_ff @(posedge bus.clk or negedge bus.reset_n) begin
		if (!bus.reset_n) begin
			wdata_hold <= '0;
			wstrb_hold <= '0;
		end else if (w_fire) begin
			wdata_hold <= bus.wdata;
			wstrb_hold <= bus.wstrb;
		end
	end

	// register store; byte lanes merged under the strobes
	always_ff @(posedge bus.clk or negedge bus.reset_n) begin
		if (!bus.reset_n) begin
			for (int i = 0; i < `CSR_NUM_REGS; i++) begin
				ctrl_word[i] <= `CSR_REG_RESET;
			end
		end else if (do_write) begin
			ctrl_word[word_index(eff_addr)] <= lane_merge(ctrl_word[word_index(eff_addr)],
				eff_data, eff_strb);
		end
	end

	// write response: bvalid raised by the edge that writes the word, held until bready
	always_ff @(posedge bus.clk or negedge bus.reset_n) begin
		if (!bus.reset_n) begin
			wr_state   <= ST_IDLE;
			bus.bvalid <= 1'b0;
		end else begin
			unique case (wr_state)
				ST_IDLE: begin
					if (do_write) begin
						wr_state   <= ST_RESP;
						bus.bvalid <= 1'b1;
					end
				end
				ST_RESP: begin
					if (b_fire) begin
						wr_state   <= ST_IDLE;
						bus.bvalid <= 1'b0;
					end
				end
				default: begin
					wr_state   <= ST_IDLE;
					bus.bvalid <= 1'b0;
				end
			endcase
		end
	end

	// every code of the window is mapped, so no write ever earns an error response
	always_ff @(posedge bus.clk or negedge bus.reset_n) begin
		if (!bus.reset_n) begin
			bus.bresp <= `RESP_OKAY;
		end else if (do_write) begin
			bus.bresp <= `RESP_OKAY;
		end
	end

	// read channel: one read in flight, arready low until rready takes the data
	always_ff @(posedge bus.clk or negedge bus.reset_n) begin
		if (!bus.reset_n) begin
			rd_state   <= ST_IDLE;
			bus.rvalid <= 1'b0;
		end else begin
			unique case (rd_state)
				ST_IDLE: begin
					if (ar_fire) begin
						rd_state   <= ST_RESP;
						bus.rvalid <= 1'b1;
					end
				end
				ST_RESP: begin
					if (r_fire) begin
						rd_state   <= ST_IDLE;
						bus.rvalid <= 1'b0;
					end
				end
				default: begin
					rd_state   <= ST_IDLE;
					bus.rvalid <= 1'b0;
				end
			endcase
		end
	end

	// data and code latched at the address handshake, frozen while rvalid stands
	always_ff @(posedge bus.clk or negedge bus.reset_n) begin
		if (!bus.reset_n) begin
			bus.rdata <= '0;
			bus.rresp <= `RESP_OKAY;
		end else if (ar_fire) begin
			bus.rdata <= read_value;
			bus.rresp <= `RESP_OKAY;
		end
	end
endmodule
`default_nettype wire

// file: hdl/csr_master.sv
// master end of the csr port: runs one register read or write per request
`timescale 1ns/1ps
`default_nettype none
`include "csr_port_consts.svh"
module csr_master
	import csr_port_pkg::*;
(
	csr_port_if.master                    bus,
	input  wire logic                     req_valid,
	input  wire logic                     req_write,
	input  wire logic [`CSR_ADDR_W-1:0]   req_addr,
	input  wire logic [`CSR_DATA_W-1:0]   req_wdata,
	input  wire logic [`CSR_STRB_W-1:0]   req_wstrb,
	output logic                          req_ready,
	output logic                          done,
	output logic [`CSR_DATA_W-1:0]        done_rdata,
	output logic [`CSR_RESP_W-1:0]        done_resp
);
	chan_state_t state;
	logic        is_write;

	assign req_ready = (state == ST_IDLE);

	// request channels: address and data held steady until their ready edge
	always_ff @(posedge bus.clk or negedge bus.reset_n) begin
		if (!bus.reset_n) begin
			state       <= ST_IDLE;
			is_write    <= 1'b0;
			bus.awvalid <= 1'b0;
			bus.wvalid  <= 1'b0;
			bus.arvalid <= 1'b0;
			bus.awaddr  <= '0;
			bus.araddr  <= '0;
			bus.wdata   <= '0;
			bus.wstrb   <= '0;
			bus.awprot  <= '0;
			bus.arprot  <= '0;
		end else begin
			unique case (state)
				ST_IDLE: begin
					if (req_valid) begin
						state    <= ST_BUSY;
						is_write <= req_write;
						if (req_write) begin
							bus.awaddr  <= req_addr;
							bus.wdata   <= req_wdata;
							bus.wstrb   <= req_wstrb;
							bus.awvalid <= 1'b1;
							bus.wvalid  <= 1'b1;
						end else begin
							bus.araddr  <= req_addr;
							bus.arvalid <= 1'b1;
						end
					end
				end
				ST_BUSY: begin
					// valids drop only at the edge that sees ready
					if (bus.awready) begin
						bus.awvalid <= 1'b0;
					end
					if (bus.wready) begin
						bus.wvalid <= 1'b0;
					end
					if (bus.arready) begin
						bus.arvalid <= 1'b0;
					end
					if ((is_write && bus.bvalid) || (!is_write && bus.rvalid)) begin
						state <= ST_IDLE;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// always ready for a response while waiting for one
	assign bus.bready = (state == ST_BUSY) && is_write;
	assign bus.rready = (state == ST_BUSY) && !is_write;

	always_ff @(posedge bus.clk or negedge bus.reset_n) begin
		if (!bus.reset_n) begin
			done       <= 1'b0;
			done_rdata <= '0;
			done_resp  <= `RESP_OKAY;
		end else begin
			done <= 1'b0;
			if (bus.bvalid && bus.bready) begin
				done      <= 1'b1;
				done_resp <= bus.bresp;
			end else if (bus.rvalid && bus.rready) begin
				done       <= 1'b1;
				done_resp  <= bus.rresp;
				done_rdata <= bus.rdata;
			end
		end
	end
endmodule
`default_nettype wire

// file: dv/csr_port_assertions.sv
// checker on the csr port interface signals
`timescale 1ns/1ps
`default_nettype none
module csr_port_assertions (
	input wire logic        clk,
	input wire logic        reset_n,
	input wire logic [3:0]  awaddr,
	input wire logic        awvalid,
	input wire logic        awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0]  wstrb,
	input wire logic        wvalid,
	input wire logic        wready,
	input wire logic [1:0]  bresp,
	input wire logic        bvalid,
	input wire logic        bready,
	input wire logic [3:0]  araddr,
	input wire logic        arvalid,
	input wire logic        arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0]  rresp,
	input wire logic        rvalid,
	input wire logic        rready
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	aw_hold_a: assert property (awvalid && !awready |=> awvalid && $stable(awaddr)) else $error("aw dropped");
	w_hold_a: assert property (wvalid && !wready |=> wvalid && $stable(wdata) && $stable(wstrb)) else $error("w dropped");
	ar_hold_a: assert property (arvalid && !arready |=> arvalid && $stable(araddr)) else $error("ar dropped");
	b_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp)) else $error("b dropped");
	r_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata)) else $error("r dropped");
	bresp_code_a: assert property (bvalid |-> bresp == 2'h0) else $error("bad bresp");
	rresp_code_a: assert property (rvalid |-> rresp == 2'h0) else $error("bad rresp");
	one_write_a: assert property (bvalid |-> !awready && !wready) else $error("write overlap");
	one_read_a: assert property (rvalid |-> !arready) else $error("read overlap");
	b_answer_a: assert property (awvalid && awready && wvalid && wready |=> bvalid) else $error("b late");
	r_answer_a: assert property (arvalid && arready |=> rvalid) else $error("r late");
	cover property (awvalid && awready && wvalid && wready);
	cover property (bvalid && bready);
	cover property (rvalid && rready);
endmodule
`default_nettype wire

// file: dv/axil_csr_slave_port_test.sv
// bench joining master and slave ends of the csr port
`timescale 1ns/1ps
`default_nettype none
module axil_csr_slave_port_test
	import csr_port_pkg::*;
;
	typedef struct {logic w; csr_addr_t a; csr_data_t d; logic [3:0] s; csr_data_t e;} row_t;
	logic       clk = 1'b0;
	logic       reset_n = 1'b0;
	logic       req_valid = 1'b0;
	logic       req_write = 1'b0;
	csr_addr_t  req_addr = 4'h0;
	csr_data_t  req_wdata = 32'h0;
	logic [3:0] req_wstrb = 4'h0;
	logic       req_ready;
	logic       done;
	csr_data_t  done_rdata;
	csr_resp_t  done_resp;
	csr_data_t  ctrl_word [4];
	csr_data_t  status_word = 32'hCAFE0001;
	int         bad_count = 0;
	int         comparisons = 0;
	// the 4'h1 strobe row and the 4'h5 and 4'h2 reads also probe that address bits 1:0 are ignored
	row_t rows [8] = '{'{1'b1, 4'h0, 32'h11223344, 4'hF, 32'h11223344},
		'{1'b1, 4'h4, 32'hAABBCCDD, 4'h5, 32'h00BB00DD}, '{1'b1, 4'h8, 32'hFFFFFFFF, 4'hA, 32'hFF00FF00},
		'{1'b1, 4'hC, 32'h12345678, 4'hF, 32'h12345678}, '{1'b0, 4'h5, 32'h0, 4'h0, 32'h00BB00DD},
		'{1'b0, 4'hC, 32'h0, 4'h0, 32'hCAFE0001}, '{1'b1, 4'h1, 32'h00000055, 4'h1, 32'h11223355},
		'{1'b0, 4'h2, 32'h0, 4'h0, 32'h11223355}};
	csr_port_if csr_port_if_inst (.clk(clk), .reset_n(reset_n));
	csr_master csr_master_inst (.bus(csr_port_if_inst), .req_valid(req_valid), .req_write(req_write),
		.req_addr(req_addr), .req_wdata(req_wdata), .req_wstrb(req_wstrb), .req_ready(req_ready),
		.done(done), .done_rdata(done_rdata), .done_resp(done_resp));
	csr_slave csr_slave_inst (.bus(csr_port_if_inst), .ctrl_word(ctrl_word), .status_word(status_word));
	csr_port_assertions csr_port_assertions_inst (.clk(clk), .reset_n(reset_n),
		.awaddr(csr_port_if_inst.awaddr), .awvalid(csr_port_if_inst.awvalid), .awready(csr_port_if_inst.awready),
		.wdata(csr_port_if_inst.wdata), .wstrb(csr_port_if_inst.wstrb),
		.wvalid(csr_port_if_inst.wvalid), .wready(csr_port_if_inst.wready),
		.bresp(csr_port_if_inst.bresp), .bvalid(csr_port_if_inst.bvalid), .bready(csr_port_if_inst.bready),
		.araddr(csr_port_if_inst.araddr),
		.arvalid(csr_port_if_inst.arvalid), .arready(csr_port_if_inst.arready), .rdata(csr_port_if_inst.rdata),
		.rresp(csr_port_if_inst.rresp), .rvalid(csr_port_if_inst.rvalid), .rready(csr_port_if_inst.rready));
	task automatic chk(input string nm, input csr_data_t seen, input csr_data_t exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// one request through the master; bounded waits end the run on a hang
	task automatic op(input logic w, input csr_addr_t a, input csr_data_t d, input logic [3:0] s);
		int n;
		n = 0;
		@(posedge clk);
		req_valid <= 1'b1;
		req_write <= w;
		req_addr <= a;
		req_wdata <= d;
		req_wstrb <= s;
		@(negedge clk);
		while (req_ready !== 1'b1 && n < 50) begin
			@(negedge clk);
			n++;
		end
		@(posedge clk);
		req_valid <= 1'b0;
		while (done !== 1'b1 && n < 50) begin
			@(negedge clk);
			n++;
		end
		if (n >= 50) begin
			bad_count++;
			summarize();
		end else begin
			chk("resp", {30'h0, done_resp}, 32'h0);
		end
	endtask
	initial begin
		forever #10 clk = ~clk;
	end
	initial begin
		repeat (8) @(posedge clk);
		chk("req_ready", {31'h0, req_ready}, 32'h1);
		reset_n <= 1'b1;
		for (int i = 0; i < 4; i++) chk("ctrl reset", ctrl_word[i], 32'h0);
		foreach (rows[i]) begin
			op(rows[i].w, rows[i].a, rows[i].d, rows[i].s);
			if (rows[i].w) chk("ctrl", ctrl_word[rows[i].a[3:2]], rows[i].e);
			else chk("rdata", done_rdata, rows[i].e);
			$display("row %0d done", i);
		end
		// status word is live, not a snapshot
		@(posedge clk);
		status_word <= 32'h0BAD0F0F;
		op(1'b0, 4'hF, 32'h0, 4'h0);
		chk("status", done_rdata, 32'h0BAD0F0F);
		$display("status test done");
		@(posedge clk);
		reset_n <= 1'b0;
		@(posedge clk);
		reset_n <= 1'b1;
		for (int i = 0; i < 4; i++) chk("ctrl reset2", ctrl_word[i], 32'h0);
		op(1'b1, 4'h8, 32'h89ABCDEF, 4'hF);
		op(1'b0, 4'h8, 32'h0, 4'h0);
		chk("rdata2", done_rdata, 32'h89ABCDEF);
		$display("reset test done");
		summarize();
	end
endmodule
`default_nettype wire
